/* File: logic/aalce_core.sv */
// AAL1 unstructured circuit emulation of one 2048 kbit/s stream over one channel.
`timescale 1ns/100ps
module aalce_core
  import aalce_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        net_ref_i,
  input  wire logic        ext_ref_i,
  output logic             octet_tick_o,
  input  wire logic [7:0]  tx_oct_i,
  input  wire logic        tx_oct_stb_i,
  output logic [7:0]       cell_tx_data_o,
  output logic             cell_tx_sop_o,
  output logic             cell_tx_valid_o,
  input  wire logic        cell_tx_ready_i,
  output logic [15:0]      cell_vc_o,
  input  wire logic [7:0]  cell_rx_data_i,
  input  wire logic        cell_rx_sop_i,
  input  wire logic        cell_rx_valid_i,
  input  wire logic [15:0] cell_rx_vc_i,
  output logic [7:0]       rx_oct_o,
  output logic             rx_oct_stb_o
);

  // Register bus group.
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        en_r, en_nxt;
  aalce_src_t  src_r, src_nxt;
  logic [15:0] vci_r, vci_nxt;
  logic        clr_r, clr_nxt;
  logic        wr_go;
  logic        sync_r;
  logic        ovf_r;
  logic [15:0] txc_r, lost_r, mis_r, herr_r;

  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;

  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    en_nxt  = en_r;
    src_nxt = src_r;
    vci_nxt = vci_r;
    clr_nxt = 1'b0;
    if (wr_go && wb_adr_i == A_CTRL && wb_sel_i[0]) begin
      en_nxt  = wb_dat_i[CTRL_EN];
      src_nxt = aalce_src_t'(wb_dat_i[CTRL_SRC +: 2]);
      clr_nxt = wb_dat_i[CTRL_CLR];
    end
    if (wr_go && wb_adr_i == A_VCI) begin
      if (wb_sel_i[0]) vci_nxt[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) vci_nxt[15:8] = wb_dat_i[15:8];
    end
    case (wb_adr_i)
      A_CTRL:   dat_nxt = {29'h0, src_r, en_r};
      A_VCI:    dat_nxt = {16'h0, vci_r};
      A_STAT:   dat_nxt = {30'h0, ovf_r, sync_r};
      A_TXCELL: dat_nxt = {16'h0, txc_r};
      A_LOST:   dat_nxt = {16'h0, lost_r};
      A_MISINS: dat_nxt = {16'h0, mis_r};
      A_HDRERR: dat_nxt = {16'h0, herr_r};
      default:  dat_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      en_r  <= EN_RST;
      src_r <= SRC_RST;
      vci_r <= VCI_RST;
      clr_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      en_r  <= en_nxt;
      src_r <= src_nxt;
      vci_r <= vci_nxt;
      clr_r <= clr_nxt;
    end
  end

  assign wb_ack_o  = ack_r;
  assign wb_dat_o  = dat_r;
  assign cell_vc_o = vci_r;

  // Reference pins are asynchronous; an edge counts once two late stages agree.
  logic [1:0] ref_pin;
  logic [1:0] ref_edge;
  assign ref_pin = {ext_ref_i, net_ref_i};

  for (genvar g = 0; g < 2; g++) begin : g_ref
    logic [2:0] s_r;
    logic       lvl_r, lvl_nxt;
    logic       edge_r, edge_nxt;
    always_comb begin
      lvl_nxt  = (s_r[1] == s_r[2]) ? s_r[2] : lvl_r;
      edge_nxt = lvl_nxt & ~lvl_r;
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s_r    <= 3'h0;
        lvl_r  <= 1'b0;
        edge_r <= 1'b0;
      end else begin
        s_r    <= {s_r[1:0], ref_pin[g]};
        lvl_r  <= lvl_nxt;
        edge_r <= edge_nxt;
      end
    end
    assign ref_edge[g] = edge_r;
  end

  // Octet tick group; the tick follows the source set in CTRL and paces only the transmit stream.
  logic [NCO_W-1:0] nco_r, nco_nxt;
  logic             tick_r, tick_nxt;
  logic [NCO_W:0]   nco_sum;

  always_comb begin
    nco_sum = {1'b0, nco_r} + {1'b0, NCO_STEP};
    nco_nxt = nco_sum[NCO_W-1:0];
    if (nco_sum >= {1'b0, NCO_MOD}) begin
      nco_nxt = NCO_W'(nco_sum - {1'b0, NCO_MOD});
    end
    case (src_r)
      SRC_NET: tick_nxt = ref_edge[0];
      SRC_EXT: tick_nxt = ref_edge[1];
      SRC_INT: tick_nxt = nco_sum >= {1'b0, NCO_MOD};
      default: tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nco_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      nco_r  <= nco_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign octet_tick_o = tick_r;

  // Transmit group: one bank fills from the stream while the other is sent.
  aalce_tx_t  tx_st_r, tx_st_nxt;
  logic       wbk_r, wbk_nxt;
  logic [5:0] wi_r, wi_nxt;
  logic       pend_r, pend_nxt;
  logic       txb_r, txb_nxt;
  logic [5:0] ri_r, ri_nxt;
  logic [2:0] sc_r, sc_nxt;
  logic [7:0] hdr_r, hdr_nxt;
  logic       ovf_nxt;
  logic [15:0] txc_nxt;
  logic       fill_done, start, take, pay_adv;
  logic [7:0] mem_q;
  logic [6:0] raddr;

  assign take      = cell_tx_valid_o & cell_tx_ready_i;
  assign fill_done = en_r & tx_oct_stb_i & (wi_r == PAY_LAST);
  assign start     = (tx_st_r == TX_IDLE) & pend_r;
  assign pay_adv   = (tx_st_r == TX_PAY) & take & (ri_r != PAY_LAST);
  assign raddr     = {txb_r, pay_adv ? ri_r + 6'h1 : ri_r};

  always_comb begin
    tx_st_nxt = tx_st_r;
    wbk_nxt   = wbk_r;
    wi_nxt    = wi_r;
    txb_nxt   = txb_r;
    ri_nxt    = ri_r;
    sc_nxt    = sc_r;
    hdr_nxt   = hdr_r;
    txc_nxt   = clr_r ? 16'h0 : txc_r;
    // When a cell completes while the previous one still waits, the waiting one is lost.
    ovf_nxt   = (ovf_r & ~clr_r) | (fill_done & pend_r & ~start);
    pend_nxt  = (pend_r & ~start) | fill_done;
    if (en_r && tx_oct_stb_i) begin
      wi_nxt = (wi_r == PAY_LAST) ? 6'h0 : wi_r + 6'h1;
      if (wi_r == PAY_LAST) wbk_nxt = ~wbk_r;
    end
    case (tx_st_r)
      TX_IDLE: begin
        if (pend_r) begin
          tx_st_nxt = TX_HDR;
          txb_nxt   = ~wbk_r;
          ri_nxt    = 6'h0;
          hdr_nxt   = {1'b0, sc_r, aalce_snp({1'b0, sc_r})};
        end
      end
      TX_HDR: begin
        if (take) tx_st_nxt = TX_PAY;
      end
      TX_PAY: begin
        if (take) begin
          if (ri_r == PAY_LAST) begin
            tx_st_nxt = TX_IDLE;
            sc_nxt    = sc_r + 3'h1;
            txc_nxt   = txc_nxt + 16'h1;
          end else begin
            ri_nxt = ri_r + 6'h1;
          end
        end
      end
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      wbk_r   <= 1'b0;
      wi_r    <= 6'h0;
      pend_r  <= 1'b0;
      txb_r   <= 1'b0;
      ri_r    <= 6'h0;
      sc_r    <= 3'h0;
      hdr_r   <= 8'h0;
      ovf_r   <= 1'b0;
      txc_r   <= 16'h0;
    end else begin
      tx_st_r <= tx_st_nxt;
      wbk_r   <= wbk_nxt;
      wi_r    <= wi_nxt;
      pend_r  <= pend_nxt;
      txb_r   <= txb_nxt;
      ri_r    <= ri_nxt;
      sc_r    <= sc_nxt;
      hdr_r   <= hdr_nxt;
      ovf_r   <= ovf_nxt;
      txc_r   <= txc_nxt;
    end
  end

  aalce_mem #(.DW(8), .AW(7)) u_buf (
    .clk_i   (clk_i),
    .we_i    (en_r & tx_oct_stb_i),
    .waddr_i ({wbk_r, wi_r}),
    .wdata_i (tx_oct_i),
    .raddr_i (raddr),
    .rdata_o (mem_q)
  );

  assign cell_tx_valid_o = (tx_st_r == TX_HDR) | (tx_st_r == TX_PAY);
  assign cell_tx_sop_o   = (tx_st_r == TX_HDR);
  assign cell_tx_data_o  = (tx_st_r == TX_HDR) ? hdr_r : mem_q;

  // Receive group: header check, count tracking and transparent payload out.
  aalce_rx_t  rx_st_r, rx_st_nxt;
  logic [5:0] rc_r, rc_nxt;
  logic [2:0] exp_r, exp_nxt;
  logic       sync_nxt;
  logic [15:0] lost_nxt, mis_nxt, herr_nxt;
  logic [7:0] rxo_r, rxo_nxt;
  logic       rxs_r, rxs_nxt;
  logic       hdr_in, hdr_ok;
  logic [2:0] gap;

  assign hdr_in = en_r & cell_rx_valid_i & cell_rx_sop_i & (rx_st_r == RX_IDLE);
  assign hdr_ok = aalce_snp(cell_rx_data_i[7:4]) == cell_rx_data_i[3:0];
  assign gap    = cell_rx_data_i[6:4] - exp_r;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rc_nxt    = rc_r;
    exp_nxt   = exp_r;
    sync_nxt  = sync_r & en_r;
    lost_nxt  = clr_r ? 16'h0 : lost_r;
    mis_nxt   = clr_r ? 16'h0 : mis_r;
    herr_nxt  = clr_r ? 16'h0 : herr_r;
    rxo_nxt   = rxo_r;
    rxs_nxt   = 1'b0;
    case (rx_st_r)
      RX_IDLE: begin
        if (hdr_in) begin
          rc_nxt    = 6'h0;
          rx_st_nxt = RX_DROP;
          if (!hdr_ok) begin
            herr_nxt = herr_nxt + 16'h1;
          end else if (cell_rx_vc_i != vci_r) begin
            rx_st_nxt = RX_DROP;
          end else if (sync_r && gap == 3'h7) begin
            mis_nxt = mis_nxt + 16'h1;
          end else begin
            if (sync_r) lost_nxt = lost_nxt + {13'h0, gap};
            exp_nxt   = cell_rx_data_i[6:4] + 3'h1;
            sync_nxt  = 1'b1;
            rx_st_nxt = RX_PAY;
          end
        end
      end
      RX_PAY, RX_DROP: begin
        if (cell_rx_valid_i) begin
          if (rx_st_r == RX_PAY) begin
            rxo_nxt = cell_rx_data_i;
            rxs_nxt = 1'b1;
          end
          rc_nxt = rc_r + 6'h1;
          if (rc_r == PAY_LAST) rx_st_nxt = RX_IDLE;
        end
      end
      default: rx_st_nxt = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st_r <= RX_IDLE;
      rc_r    <= 6'h0;
      exp_r   <= 3'h0;
      sync_r  <= 1'b0;
      lost_r  <= 16'h0;
      mis_r   <= 16'h0;
      herr_r  <= 16'h0;
      rxo_r   <= 8'h0;
      rxs_r   <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rc_r    <= rc_nxt;
      exp_r   <= exp_nxt;
      sync_r  <= sync_nxt;
      lost_r  <= lost_nxt;
      mis_r   <= mis_nxt;
      herr_r  <= herr_nxt;
      rxo_r   <= rxo_nxt;
      rxs_r   <= rxs_nxt;
    end
  end

  assign rx_oct_o     = rxo_r;
  assign rx_oct_stb_o = rxs_r;

  // Helper state read only by the checks below.
  logic [2:0] last_sc_r;
  logic       seen_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_sc_r <= 3'h0;
      seen_r    <= 1'b0;
    end else if (cell_tx_sop_o && take) begin
      last_sc_r <= cell_tx_data_o[6:4];
      seen_r    <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

  property p_ack_answer;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack");

  property p_hdr_check;
    cell_tx_sop_o |-> !cell_tx_data_o[7] && cell_tx_data_o[3:0] == aalce_snp(cell_tx_data_o[7:4]);
  endproperty
  a_hdr_check: assert property (p_hdr_check) else $error("bad header check");

  property p_seq_step;
    (cell_tx_sop_o && take && seen_r) |-> cell_tx_data_o[6:4] == last_sc_r + 3'h1;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("count skipped");

  property p_hdr_then_pay;
    (cell_tx_sop_o && take) |=> cell_tx_valid_o && !cell_tx_sop_o;
  endproperty
  a_hdr_then_pay: assert property (p_hdr_then_pay) else $error("no payload");

  property p_vc_own;
    $changed(cell_vc_o) |-> $past(wr_go && wb_adr_i == A_VCI);
  endproperty
  a_vc_own: assert property (p_vc_own) else $error("channel drift");

  property p_rx_pass;
    (rx_st_r == RX_PAY && cell_rx_valid_i) |=>
      rx_oct_stb_o && rx_oct_o == $past(cell_rx_data_i);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("payload altered");

  property p_lost;
    (hdr_in && hdr_ok && sync_r && cell_rx_vc_i == vci_r && gap != 3'h7 && !clr_r)
      |=> lost_r == $past(lost_r) + {13'h0, $past(gap)};
  endproperty
  a_lost: assert property (p_lost) else $error("lost count wrong");

  property p_tick_gap;
    (src_r == SRC_INT && octet_tick_o) |=> !octet_tick_o [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too fast");

  // One instance carries one stream; replicate the module per stream.

endmodule : aalce_core

/* File: include/aalce_pkg.sv */
// Constants, types and header check code of the AAL1 E1 circuit emulation block.
package aalce_pkg;

  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned LINE_KBPS = 2048;
  localparam int unsigned OCT_HZ    = LINE_KBPS * 1000 / 8;

  // Octet tick generator: a phase accumulator gives the exact average octet rate.
  localparam int          NCO_W    = 25;
  localparam logic [24:0] NCO_MOD  = 25'(CLK_HZ);
  localparam logic [24:0] NCO_STEP = 25'(OCT_HZ);

  localparam int         PAY_OCT  = 47;
  localparam logic [5:0] PAY_LAST = 6'(PAY_OCT - 1);

  // Register byte addresses.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_VCI    = 8'h04;
  localparam logic [7:0] A_STAT   = 8'h08;
  localparam logic [7:0] A_TXCELL = 8'h0c;
  localparam logic [7:0] A_LOST   = 8'h10;
  localparam logic [7:0] A_MISINS = 8'h14;
  localparam logic [7:0] A_HDRERR = 8'h18;

  // Field positions.
  localparam int CTRL_EN   = 0;
  localparam int CTRL_SRC  = 1;
  localparam int CTRL_CLR  = 3;
  localparam int STAT_SYNC = 0;
  localparam int STAT_OVF  = 1;

  typedef enum logic [1:0] {
    SRC_NET = 2'h0,
    SRC_EXT = 2'h1,
    SRC_INT = 2'h2
  } aalce_src_t;

  localparam logic        EN_RST  = 1'b0;
  localparam aalce_src_t  SRC_RST = SRC_INT;
  localparam logic [15:0] VCI_RST = 16'h0020;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_HDR  = 3'h2,
    TX_PAY  = 3'h4
  } aalce_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_PAY  = 3'h2,
    RX_DROP = 3'h4
  } aalce_rx_t;

  // Check field of a sequence number: CRC-3 (x^3+x+1) then even parity.
  function automatic logic [3:0] aalce_snp(input logic [3:0] sn);
    logic [2:0] rem;
    logic       fb;
    rem = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      fb  = sn[i] ^ rem[2];
      rem = {rem[1], rem[0] ^ fb, fb};
    end
    return {rem, ^{sn, rem}};
  endfunction : aalce_snp

endpackage : aalce_pkg

/* File: logic/aalce_mem.sv */
// Payload buffer memory with a registered read port.
`timescale 1ns/100ps
module aalce_mem #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  if (DW < 1 || AW < 1) begin : g_chk
    $error("aalce_mem: widths must be positive");
  end

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule : aalce_mem

/* File: verif/aalce_vc_model.sv */
// Service node end of the channel: a stalling cell sink and a cell source.
`timescale 1ns/100ps
module aalce_vc_model (
  input  wire logic        clk_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_sop_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  output logic [7:0]       rx_data_o,
  output logic             rx_sop_o,
  output logic             rx_valid_o,
  output logic [15:0]      rx_vc_o
);
  logic [8:0] got [$];
  logic [1:0] stall_r;

  initial begin
    stall_r    = 2'h0;
    tx_ready_o = 1'b0;
    rx_data_o  = 8'h5a;
    rx_sop_o   = 1'b0;
    rx_valid_o = 1'b0;
    rx_vc_o    = 16'h0000;
  end

  // The sink refuses one cycle in four, so held octets are exercised.
  always @(posedge clk_i) begin
    stall_r    <= stall_r + 2'h1;
    tx_ready_o <= (stall_r != 2'h3);
    if (tx_valid_i === 1'b1 && tx_ready_o) begin
      got.push_back({tx_sop_i, tx_data_i});
    end
  end

  // A whole cell is sent without gaps; afterwards the data lines show the inverse.
  task automatic send(input logic [7:0] hdr, input logic [15:0] vc, input logic [7:0] base);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_sop_o   <= 1'b1;
    rx_data_o  <= hdr;
    rx_vc_o    <= vc;
    for (int i = 0; i < 47; i++) begin
      @(posedge clk_i);
      rx_sop_o  <= 1'b0;
      rx_vc_o   <= ~vc;
      rx_data_o <= base + 8'(i);
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~(base + 8'h2e);
  endtask : send
endmodule : aalce_vc_model

/* File: verif/tb_top.sv */
// Self-checking bench of the circuit emulation block with its channel partner.
`timescale 1ns/100ps
module tb_top
  import aalce_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, net_ref_i, ext_ref_i, tx_oct_stb_i, ack, tick, ready;
  logic        sop, valid, rsop, rvalid, rx_oct_stb_o;
  logic [7:0]  adr, tx_oct_i, tdata, rdata, rx_oct_o;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, q;
  logic [15:0] vc_o, rvc;
  logic [7:0]  rxq [$];
  int          err_total, cmp_count, ticks;

  aalce_core aalce_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .net_ref_i(net_ref_i), .ext_ref_i(ext_ref_i), .octet_tick_o(tick),
    .tx_oct_i(tx_oct_i), .tx_oct_stb_i(tx_oct_stb_i), .cell_tx_data_o(tdata),
    .cell_tx_sop_o(sop), .cell_tx_valid_o(valid), .cell_tx_ready_i(ready),
    .cell_vc_o(vc_o), .cell_rx_data_i(rdata), .cell_rx_sop_i(rsop),
    .cell_rx_valid_i(rvalid), .cell_rx_vc_i(rvc), .rx_oct_o(rx_oct_o),
    .rx_oct_stb_o(rx_oct_stb_o));

  aalce_vc_model aalce_vc_model_i (.clk_i(clk_i), .tx_data_i(tdata), .tx_sop_i(sop),
    .tx_valid_i(valid), .tx_ready_o(ready), .rx_data_o(rdata), .rx_sop_o(rsop),
    .rx_valid_o(rvalid), .rx_vc_o(rvc));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (rx_oct_stb_o === 1'b1) rxq.push_back(rx_oct_o);

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle: held until ack is sampled high, then one idle cycle.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  function automatic logic [7:0] hdr(input logic [2:0] sc);
    logic [2:0] r;
    logic       f;
    r = 3'h0;
    for (int i = 3; i >= 0; i--) begin
      f = ((i == 3) ? 1'b0 : sc[i]) ^ r[2];
      r = {r[1], r[0] ^ f, f};
    end
    return {1'b0, sc, r, ^{sc, r}};
  endfunction : hdr

  // Pulses one reference pin and counts the ticks that follow it.
  task automatic ref_pulse(input int pin, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge clk_i);
    if (pin == 0) net_ref_i <= 1'b1;
    else ext_ref_i <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (i == 4) begin
        net_ref_i <= 1'b0;
        ext_ref_i <= 1'b0;
      end
      if (tick === 1'b1) n++;
    end
    chk(32'(n), exp);
  endtask : ref_pulse

  task automatic feed_cell(input logic [7:0] base);
    for (int i = 0; i < 47; i++) begin
      do @(posedge clk_i); while (tick !== 1'b1);
      tx_oct_i     <= base + 8'(i);
      tx_oct_stb_i <= 1'b1;
      @(posedge clk_i);
      tx_oct_stb_i <= 1'b0;
    end
  endtask : feed_cell

  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end

  initial begin
    {rst_i, cyc, stb, we, net_ref_i, ext_ref_i, tx_oct_stb_i} = 7'h40;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'h0;
    tx_oct_i = 8'h00;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(A_CTRL, 1'b0, 32'h0); chk(q, 32'h0000_0004);
    wb(A_VCI, 1'b0, 32'h0); chk(q, 32'h0000_0020);
    wb(A_STAT, 1'b0, 32'h0); chk(q, 32'h0);
    wb(8'h1c, 1'b1, 32'hffff_ffff);
    wb(8'h1c, 1'b0, 32'h0); chk(q, 32'h0);
    wb(A_VCI, 1'b1, 32'h0000_ffff, 4'h1);
    wb(A_VCI, 1'b0, 32'h0); chk(q, 32'h0000_00ff);
    wb(A_VCI, 1'b1, 32'h0000_0123);
    @(posedge clk_i); chk(32'(vc_o), 32'h0123);
    for (int s = 0; s < 2; s++) begin
      wb(A_CTRL, 1'b1, 32'(s * 2 + 1));
      repeat (4) @(posedge clk_i);
      ref_pulse(s, 32'h1);
      ref_pulse(1 - s, 32'h0);
    end
    wb(A_CTRL, 1'b1, 32'h5);
    // 3125 cycles of 40 ns are 125 us, which hold exactly 32 octets of the stream.
    ticks = 0;
    repeat (3125) begin
      @(posedge clk_i);
      if (tick === 1'b1) ticks++;
    end
    chk(32'(ticks), 32'd32);
    feed_cell(8'h10);
    feed_cell(8'ha0);
    for (int n = 0; n < 4000 && aalce_vc_model_i.got.size() < 96; n++) @(posedge clk_i);
    chk(32'(aalce_vc_model_i.got.size()), 32'd96);
    for (int k = 0; k < 96; k++) begin
      if (k % 48 == 0) chk(32'(aalce_vc_model_i.got[k]), {24'h1, hdr(3'(k / 48))});
      else chk(32'(aalce_vc_model_i.got[k]), 32'(((k < 48) ? 8'h10 : 8'ha0) + 8'(k % 48 - 1)));
    end
    wb(A_TXCELL, 1'b0, 32'h0); chk(q, 32'h2);
    aalce_vc_model_i.send(hdr(3'h0), 16'h0123, 8'h30);
    wb(A_STAT, 1'b0, 32'h0); chk(32'(q[STAT_SYNC]), 32'h1);
    aalce_vc_model_i.send(hdr(3'h2), 16'h0123, 8'h60);
    aalce_vc_model_i.send(hdr(3'h3) ^ 8'h01, 16'h0123, 8'h90);
    aalce_vc_model_i.send(hdr(3'h3), 16'h0124, 8'hc0);
    aalce_vc_model_i.send(hdr(3'h2), 16'h0123, 8'he0);
    repeat (4) @(posedge clk_i);
    chk(32'(rxq.size()), 32'd94);
    for (int k = 0; k < 94; k++) chk(32'(rxq[k]), 32'(((k < 47) ? 8'h30 : 8'h60) + 8'(k % 47)));
    wb(A_LOST, 1'b0, 32'h0); chk(q, 32'h1);
    wb(A_HDRERR, 1'b0, 32'h0); chk(q, 32'h1);
    wb(A_MISINS, 1'b0, 32'h0); chk(q, 32'h1);
    wb(A_CTRL, 1'b1, 32'h0000_000d);
    wb(A_TXCELL, 1'b0, 32'h0); chk(q, 32'h0);
    wb(A_CTRL, 1'b0, 32'h0); chk(q, 32'h0000_0005);
    // Six cells strobed on every cycle fill faster than the stalling sink drains them.
    repeat (282) begin
      @(posedge clk_i);
      tx_oct_stb_i <= 1'b1;
    end
    @(posedge clk_i);
    tx_oct_stb_i <= 1'b0;
    wb(A_STAT, 1'b0, 32'h0); chk(q, 32'h3);
    wb(A_CTRL, 1'b1, 32'h0000_000d);
    wb(A_STAT, 1'b0, 32'h0); chk(q, 32'h1);
    print_verdict();
  end
endmodule : tb_top
